//--- core/char_serdes.sv
// Eleven-bit character transmitter and receiver with a two-entry send buffer.
`timescale 1ns/1ps
`include "mbus_link_params.svh"
module char_serdes #(
  parameter int BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  input wire logic rxd,
  output logic txd
);
  localparam logic [16:0] BIT_N = 17'(BIT_CYCLES - 1);
  localparam logic [16:0] HALF_N = 17'(BIT_CYCLES / 2 - 1);

  if (BIT_CYCLES < 4 || BIT_CYCLES > 131071) begin : g_chk
    $error("BIT_CYCLES out of range");
  end

  mbus_link_pkg::serdes_t s;
  mbus_link_pkg::serdes_t next_s;
  logic [1:0][7:0] b;
  logic [1:0] cnt;
  logic [10:0] sh;

  assign tx_ready = s.tx_cnt != 2'h2;
  assign txd = s.txd;
  assign rx_data = s.rx_data;
  assign rx_valid = s.rx_valid;
  assign rx_err = s.rx_err;

  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;
    b = s.tx_buf;
    cnt = s.tx_cnt;
    sh = {rxd, s.rx_shift[10:1]};
    // -----------------------------------------------------------------
    // Transmit
    // -----------------------------------------------------------------
    if (s.tx_bits == 4'h0 && cnt != 2'h0) begin
      next_s.tx_shift = {1'b1, ^b[0], b[0], 1'b0};
      next_s.tx_bits = `CHAR_BITS;
      next_s.tx_tmr = BIT_N;
      b[0] = b[1];
      cnt = cnt - 2'h1;
    end else if (s.tx_bits != 4'h0) begin
      if (s.tx_tmr == 17'h0) begin
        next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
        next_s.tx_bits = s.tx_bits - 4'h1;
        next_s.tx_tmr = BIT_N;
      end else begin
        next_s.tx_tmr = s.tx_tmr - 17'h1;
      end
    end
    // A word offered while the buffer is full is simply not taken, so a
    // stalled line never drops one.
    if (tx_valid && s.tx_cnt != 2'h2) begin
      b[cnt[0]] = tx_data;
      cnt = cnt + 2'h1;
    end
    next_s.tx_buf = b;
    next_s.tx_cnt = cnt;
    next_s.txd = (next_s.tx_bits != 4'h0) ? next_s.tx_shift[0]
                                         : `IDLE_LEVEL;
    // -----------------------------------------------------------------
    // Receive, sampling each bit in its middle
    // -----------------------------------------------------------------
    if (s.rx_bits == 4'h0) begin
      if (rxd == 1'b0) begin
        next_s.rx_bits = `CHAR_BITS;
        next_s.rx_tmr = HALF_N;
      end
    end else if (s.rx_tmr != 17'h0) begin
      next_s.rx_tmr = s.rx_tmr - 17'h1;
    end else if (s.rx_bits == `CHAR_BITS && rxd) begin
      next_s.rx_bits = 4'h0;
    end else begin
      next_s.rx_shift = sh;
      next_s.rx_bits = s.rx_bits - 4'h1;
      next_s.rx_tmr = BIT_N;
      if (s.rx_bits == 4'h1) begin
        next_s.rx_data = sh[8:1];
        next_s.rx_valid = 1'b1;
        next_s.rx_err = !sh[10] || (^sh[9:1]);
        // Leave the stop bit's second half to the idle search.
        next_s.rx_bits = 4'h0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.txd <= `IDLE_LEVEL;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- core/master_end.sv
// Master end: builds request telegrams and classifies the meter's answers.
`timescale 1ns/1ps
`include "mbus_link_params.svh"
module master_end #(
  parameter int BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  mbus_link_if.master link,
  input wire logic cmd_valid,
  input wire mbus_link_pkg::mcmd_t cmd_kind,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic ans_valid,
  output logic [7:0] ans_byte,
  output logic ans_err,
  output mbus_link_pkg::frame_kind_t ans_kind
);
  mbus_link_pkg::master_t s;
  mbus_link_pkg::master_t next_s;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  logic tx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic [7:0] flen;

  char_serdes #(.BIT_CYCLES(BIT_CYCLES)) u_serdes (
    .mclk(mclk),
    .rst(rst),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_err(rx_err),
    .rxd(link.s2m),
    .txd(link.m2s)
  );

  function automatic logic [7:0] req_byte(input logic [7:0] i,
                                          input mbus_link_pkg::master_t m);
    logic [7:0] c;
    c = (m.kind == mbus_link_pkg::MC_NKE) ? `C_NKE :
        (m.kind == mbus_link_pkg::MC_REQ) ? `C_REQ_UD2 : `C_SND_UD;
    if (m.kind != mbus_link_pkg::MC_NKE && m.fcb) c = c | `FCB_BIT;
    req_byte = `STOP_CHAR;
    if (m.kind != mbus_link_pkg::MC_SND) begin
      unique case (i)
        8'h0: req_byte = `SHORT_START;
        8'h1: req_byte = c;
        8'h2: req_byte = m.addr;
        8'h3: req_byte = c + m.addr;
        default: req_byte = `STOP_CHAR;
      endcase
    end else begin
      unique case (i)
        8'h0, 8'h3: req_byte = `LONG_START;
        8'h1, 8'h2: req_byte = `L_OVERHEAD + 8'h1;
        8'h4: req_byte = c;
        8'h5: req_byte = m.addr;
        8'h6: req_byte = `CI_SEND;
        8'h7: req_byte = m.cmd;
        8'h8: req_byte = c + m.addr + `CI_SEND + m.cmd;
        default: req_byte = `STOP_CHAR;
      endcase
    end
  endfunction

  assign cmd_ready = s.cmd_ready;
  assign ans_valid = s.ans_valid;
  assign ans_byte = s.ans_byte;
  assign ans_err = s.ans_err;
  assign ans_kind = s.ans_kind;
  assign tx_valid = s.st == mbus_link_pkg::M_SEND;
  assign tx_data = req_byte(s.idx, s);
  assign flen = (s.kind == mbus_link_pkg::MC_SND) ? `MSND_LEN : `MSHORT_LEN;

  always_comb begin
    next_s = s;
    next_s.ans_valid = 1'b0;
    // -----------------------------------------------------------------
    // Request
    // -----------------------------------------------------------------
    unique case (s.st)
      mbus_link_pkg::M_IDLE:
        if (cmd_valid) begin
          next_s.kind = cmd_kind;
          next_s.addr = cmd_addr;
          next_s.cmd = cmd_byte;
          next_s.idx = 8'h0;
          next_s.first = 1'b0;
          if (cmd_kind == mbus_link_pkg::MC_NKE) next_s.fcb = 1'b0;
          next_s.st = mbus_link_pkg::M_SEND;
        end
      mbus_link_pkg::M_SEND:
        if (tx_ready) begin
          next_s.idx = s.idx + 8'h1;
          if (s.idx + 8'h1 == flen) begin
            next_s.st = mbus_link_pkg::M_IDLE;
            next_s.first = 1'b1;
          end
        end
    endcase
    next_s.cmd_ready = next_s.st == mbus_link_pkg::M_IDLE;
    // -----------------------------------------------------------------
    // Answer bytes, the first one classified
    // -----------------------------------------------------------------
    if (rx_valid) begin
      next_s.ans_valid = 1'b1;
      next_s.ans_byte = rx_data;
      next_s.ans_err = rx_err;
      if (s.first) begin
        next_s.first = 1'b0;
        next_s.ans_kind = rx_err ? mbus_link_pkg::FK_BAD
                                 : mbus_link_pkg::frame_kind(rx_data);
        // The frame count bit toggles as soon as the first byte of the reply to an MC_REQ request arrives intact as the long start.
        if (!rx_err && s.kind == mbus_link_pkg::MC_REQ &&
            mbus_link_pkg::frame_kind(rx_data) == mbus_link_pkg::FK_LONG) begin
          next_s.fcb = !s.fcb;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.cmd_ready <= 1'b1;
      s.ans_kind <= mbus_link_pkg::FK_BAD;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- core/mbus_link_if.sv
// Optical link between the meter and its single bus master.
`timescale 1ns/1ps
interface mbus_link_if;
  logic m2s;
  logic s2m;
  modport meter (input m2s, output s2m);
  modport master (output m2s, input s2m);
endinterface

//--- core/mbus_link_params.svh
// Constants of the meter link framer: character, telegram and object layout.
// Operation
// - Idle transmit line stays at mark
// - Character: start, eight data, even parity, stop
// - Data bits sent and received LSB first
// - Bit rate fixed at 2400 bps
// - One master; meter only answers, never initiates
// - First byte selects single, short or long format
// - Acknowledge is the lone byte E5h
// - Short frame: 10h, control, address, checksum, 16h
// - Long frame: 68h, length twice, 68h, C, A, CI
// - Long frame: 0-252 data, checksum, 16h
// - Total energy readable, never resettable
// - Tariff one energy readable and resettable
// - Power-fail counter counts switch-offs, resettable
// - Reset counter counts energy clears, read-only
// - Flags readable; only some clearable
// - Firmware version readable; writes rejected
// - Every telegram field is one byte
// - Length equals user-data bytes plus three
// - Broadcast address 255 accepted, never answered
`ifndef MBUS_LINK_PARAMS_SVH
`define MBUS_LINK_PARAMS_SVH
`define CLK_HZ 200000000
`define BAUD_BPS 2400
`define BIT_CYCLES (`CLK_HZ / `BAUD_BPS)
`define CHAR_BITS 4'hb
`define IDLE_LEVEL 1'b1
`define ACK_CHAR 8'he5
`define SHORT_START 8'h10
`define LONG_START 8'h68
`define STOP_CHAR 8'h16
`define L_OVERHEAD 8'h03
`define ADDR_DEFAULT 8'h00
`define ADDR_PTP 8'hfe
`define ADDR_BCAST 8'hff
`define C_NKE 8'h40
`define C_SND_UD 8'h53
`define C_REQ_UD2 8'h5b
`define C_RSP_UD 8'h08
`define FCB_BIT 8'h20
`define CI_SEND 8'h51
`define CI_RSP 8'h72
`define RSP_DATA_LEN 8'h0e
`define RSP_LEN 8'h17
`define RSP_DATA_POS 8'h07
`define RSP_CS_POS 8'h15
`define CMD_RST_ENERGY 0
`define CMD_RST_PFAIL 1
`define CMD_CLR_FLAGS 2
`define CMD_KNOWN 8'h07
`define CLEARABLE_FLAGS 8'h1c
`define FW_VERSION 8'h01
`define MSND_LEN 8'h0a
`define MSHORT_LEN 8'h05
`endif

//--- core/mbus_link_pkg.sv
// Shared types and decoding of the meter link framer.
`include "mbus_link_params.svh"
package mbus_link_pkg;
  typedef enum logic [1:0] {FK_ACK, FK_SHORT, FK_LONG, FK_BAD} frame_kind_t;
  typedef enum {P_IDLE, P_LEN1, P_LEN2, P_START2, P_BODY, P_CSUM, P_STOP,
    P_SEND} parse_state_t;
  typedef enum {REP_ACK, REP_RSP} reply_t;
  typedef enum logic [1:0] {MC_NKE, MC_REQ, MC_SND} mcmd_t;
  typedef enum {M_IDLE, M_SEND} mstate_t;

  typedef struct packed {
    logic [1:0][7:0] tx_buf;
    logic [1:0] tx_cnt;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [16:0] tx_tmr;
    logic txd;
    logic [10:0] rx_shift;
    logic [3:0] rx_bits;
    logic [16:0] rx_tmr;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_err;
  } serdes_t;

  typedef struct packed {
    parse_state_t st;
    logic is_long;
    logic [7:0] idx;
    logic [7:0] len;
    logic [7:0] c;
    logic [7:0] a;
    logic [7:0] ci;
    logic [7:0] cmd;
    logic [7:0] sum;
    reply_t rep;
    logic [7:0] tidx;
    logic [7:0] tsum;
    logic [31:0] e_total;
    logic [31:0] e_reset;
    logic [15:0] pf_cnt;
    logic [15:0] rs_cnt;
    logic [7:0] flags;
    logic rx_ok;
    logic tx_act;
    logic deny;
  } meter_t;

  typedef struct packed {
    mstate_t st;
    mcmd_t kind;
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [7:0] idx;
    logic fcb;
    logic first;
    logic cmd_ready;
    logic ans_valid;
    logic [7:0] ans_byte;
    logic ans_err;
    frame_kind_t ans_kind;
  } master_t;

  // The start character alone tells the format of what follows.
  function automatic frame_kind_t frame_kind(input logic [7:0] b);
    frame_kind = FK_BAD;
    if (b == `ACK_CHAR) frame_kind = FK_ACK;
    else if (b == `SHORT_START) frame_kind = FK_SHORT;
    else if (b == `LONG_START) frame_kind = FK_LONG;
  endfunction
endpackage

//--- core/meter_end.sv
// Meter (slave) end: telegram parser, object store and reply generator.
`timescale 1ns/1ps
`include "mbus_link_params.svh"
module meter_end #(
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter logic [7:0] PRIMARY_ADDR = `ADDR_DEFAULT,
  parameter logic [7:0] FW_VERSION = `FW_VERSION,
  parameter logic [7:0] CLEARABLE = `CLEARABLE_FLAGS
) (
  input wire logic mclk,
  input wire logic rst,
  mbus_link_if.meter link,
  input wire logic energy_pulse,
  input wire logic switch_off,
  input wire logic [7:0] flag_set,
  output logic rx_ok,
  output logic tx_act,
  output logic deny
);
  if (PRIMARY_ADDR > 8'hfa) begin : g_chk
    $error("PRIMARY_ADDR must be 0 to 250");
  end

  mbus_link_pkg::meter_t s;
  mbus_link_pkg::meter_t next_s;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  logic tx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic [7:0] base_c;
  logic addr_ok;
  logic bcast;
  logic do_ack;
  logic do_rsp;

  char_serdes #(.BIT_CYCLES(BIT_CYCLES)) u_serdes (
    .mclk(mclk),
    .rst(rst),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_err(rx_err),
    .rxd(link.m2s),
    .txd(link.s2m)
  );

  // Byte idx of the answer; only the checksum position depends on history.
  function automatic logic [7:0] rsp_byte(input logic [7:0] i,
                                          input mbus_link_pkg::meter_t m);
    logic [111:0] d;
    d = {FW_VERSION, m.flags, m.rs_cnt, m.pf_cnt, m.e_reset, m.e_total};
    rsp_byte = `STOP_CHAR;
    if (m.rep == mbus_link_pkg::REP_ACK) rsp_byte = `ACK_CHAR;
    else if (i == 8'h0 || i == 8'h3) rsp_byte = `LONG_START;
    else if (i < 8'h3) rsp_byte = `RSP_DATA_LEN + `L_OVERHEAD;
    else if (i == 8'h4) rsp_byte = `C_RSP_UD;
    else if (i == 8'h5) rsp_byte = PRIMARY_ADDR;
    else if (i == 8'h6) rsp_byte = `CI_RSP;
    else if (i < `RSP_CS_POS) rsp_byte = d[8 * (i - `RSP_DATA_POS) +: 8];
    else if (i == `RSP_CS_POS) rsp_byte = m.tsum;
  endfunction

  assign rx_ok = s.rx_ok;
  assign tx_act = s.tx_act;
  assign deny = s.deny;
  assign tx_valid = s.st == mbus_link_pkg::P_SEND;
  assign tx_data = rsp_byte(s.tidx, s);
  assign base_c = s.c & ~`FCB_BIT;
  assign bcast = s.a == `ADDR_BCAST;
  assign addr_ok = s.a == PRIMARY_ADDR || s.a == `ADDR_PTP || bcast;

  always_comb begin
    next_s = s;
    next_s.rx_ok = 1'b0;
    next_s.deny = 1'b0;
    do_ack = 1'b0;
    do_rsp = 1'b0;
    // -----------------------------------------------------------------
    // Objects
    // -----------------------------------------------------------------
    if (energy_pulse) begin
      next_s.e_total = s.e_total + 32'h1;
      next_s.e_reset = s.e_reset + 32'h1;
    end
    if (switch_off) next_s.pf_cnt = s.pf_cnt + 16'h1;
    next_s.flags = s.flags | flag_set;
    // -----------------------------------------------------------------
    // Receive path; a bad character drops the telegram
    // -----------------------------------------------------------------
    if (rx_valid && s.st != mbus_link_pkg::P_SEND) begin
      if (rx_err) begin
        next_s.st = mbus_link_pkg::P_IDLE;
      end else begin
        unique case (s.st)
          mbus_link_pkg::P_IDLE: begin
            next_s.idx = 8'h0;
            next_s.sum = 8'h0;
            next_s.ci = 8'h0;
            next_s.cmd = 8'h0;
            unique case (mbus_link_pkg::frame_kind(rx_data))
              mbus_link_pkg::FK_SHORT: begin
                next_s.is_long = 1'b0;
                next_s.len = 8'h2;
                next_s.st = mbus_link_pkg::P_BODY;
              end
              mbus_link_pkg::FK_LONG: begin
                next_s.is_long = 1'b1;
                next_s.st = mbus_link_pkg::P_LEN1;
              end
              default: next_s.st = mbus_link_pkg::P_IDLE;
            endcase
          end
          mbus_link_pkg::P_LEN1: begin
            next_s.len = rx_data;
            next_s.st = rx_data < `L_OVERHEAD ? mbus_link_pkg::P_IDLE
                                              : mbus_link_pkg::P_LEN2;
          end
          mbus_link_pkg::P_LEN2:
            next_s.st = rx_data == s.len ? mbus_link_pkg::P_START2
                                         : mbus_link_pkg::P_IDLE;
          mbus_link_pkg::P_START2:
            next_s.st = rx_data == `LONG_START ? mbus_link_pkg::P_BODY
                                               : mbus_link_pkg::P_IDLE;
          mbus_link_pkg::P_BODY: begin
            // Data beyond the first command byte is summed but not kept.
            if (s.idx == 8'h0) next_s.c = rx_data;
            if (s.idx == 8'h1) next_s.a = rx_data;
            if (s.idx == 8'h2) next_s.ci = rx_data;
            if (s.idx == 8'h3) next_s.cmd = rx_data;
            next_s.sum = s.sum + rx_data;
            next_s.idx = s.idx + 8'h1;
            if (s.idx + 8'h1 == s.len) begin
              next_s.st = mbus_link_pkg::P_CSUM;
            end
          end
          mbus_link_pkg::P_CSUM:
            next_s.st = rx_data == s.sum ? mbus_link_pkg::P_STOP
                                         : mbus_link_pkg::P_IDLE;
          mbus_link_pkg::P_STOP: begin
            next_s.st = mbus_link_pkg::P_IDLE;
            if (rx_data == `STOP_CHAR && addr_ok) begin
              if (!s.is_long && s.c == `C_NKE) begin
                next_s.rx_ok = 1'b1;
                do_ack = 1'b1;
              end else if (!s.is_long && base_c == `C_REQ_UD2) begin
                next_s.rx_ok = 1'b1;
                do_rsp = 1'b1;
              end else if (s.is_long && base_c == `C_SND_UD &&
                           s.ci == `CI_SEND && s.len > `L_OVERHEAD) begin
                next_s.rx_ok = 1'b1;
                if ((s.cmd & ~`CMD_KNOWN) != 8'h0) begin
                  // Any unknown bit, e.g. a firmware write, voids it all.
                  next_s.deny = 1'b1;
                end else begin
                  do_ack = 1'b1;
                  if (s.cmd[`CMD_RST_ENERGY]) begin
                    next_s.e_reset = 32'h0;
                    next_s.rs_cnt = s.rs_cnt + 16'h1;
                  end
                  if (s.cmd[`CMD_RST_PFAIL]) begin
                    next_s.pf_cnt = {15'h0, switch_off};
                  end
                  if (s.cmd[`CMD_CLR_FLAGS]) begin
                    // A flag raised in the same cycle survives the clear.
                    next_s.flags = (s.flags & ~CLEARABLE) | flag_set;
                  end
                end
              end
              // Answers only follow a request from the master.
              if ((do_ack || do_rsp) && !bcast) begin
                next_s.rep = do_rsp ? mbus_link_pkg::REP_RSP
                                    : mbus_link_pkg::REP_ACK;
                next_s.tidx = 8'h0;
                next_s.tsum = 8'h0;
                next_s.st = mbus_link_pkg::P_SEND;
              end
            end
          end
          mbus_link_pkg::P_SEND: next_s.st = mbus_link_pkg::P_SEND;
        endcase
      end
    end
    // -----------------------------------------------------------------
    // Reply; received characters are ignored while answering
    // -----------------------------------------------------------------
    if (s.st == mbus_link_pkg::P_SEND && tx_ready) begin
      next_s.tidx = s.tidx + 8'h1;
      if (s.tidx > 8'h3 && s.tidx < `RSP_CS_POS) begin
        next_s.tsum = s.tsum + tx_data;
      end
      if (s.rep == mbus_link_pkg::REP_ACK || s.tidx + 8'h1 == `RSP_LEN) begin
        next_s.st = mbus_link_pkg::P_IDLE;
      end
    end
    next_s.tx_act = next_s.st == mbus_link_pkg::P_SEND;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- verif/meter_bus_frame_link_checker.sv
// Wire checks on both serial lines of the meter link.
`timescale 1ns/1ps
module meter_bus_frame_link_checker #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic m2s,
  input wire logic s2m
);
  // ------------------------------------------------------------
  // Character trackers, index 0 is the master line
  // ------------------------------------------------------------
  localparam int B = BIT_CYCLES;
  logic [1:0] ln;
  logic [1:0] busy;
  logic [1:0] nf;
  logic [1:0] st;
  int cnt [2];
  logic [8:0] sh [2];
  assign ln = {s2m, m2s};
  assign st = ~busy & ~ln;
  // The count restarts on the first low sample, so bit k spans k*B onward.
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 2'b00;
      nf <= 2'b01;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (st[i]) begin
          busy[i] <= 1'b1;
          cnt[i] <= 1;
        end else if (busy[i]) begin
          cnt[i] <= cnt[i] + 1;
          if (cnt[i] % B == B / 2 && cnt[i] > B && cnt[i] < 10 * B) begin
            sh[i] <= {ln[i], sh[i][8:1]};
          end
          if (cnt[i] == 11 * B - 1) begin
            busy[i] <= 1'b0;
            nf[i] <= 1'b0;
            nf[1 - i] <= 1'b1;
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_end(i);
    busy[i] && cnt[i] == 11 * B - 1;
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> m2s && s2m)
    else $error("line not at mark after reset");
  for (genvar g = 0; g < 2; g++) begin : line_g
    start_low_a: assert property (busy[g] && cnt[g] < B |-> !ln[g])
      else $error("start bit not held low");
    bit_hold_a: assert property (
      busy[g] && cnt[g] % B != 0 |-> $stable(ln[g]))
      else $error("line moved inside a bit time");
    stop_mark_a: assert property (busy[g] && cnt[g] >= 10 * B |-> ln[g])
      else $error("stop bit not at mark");
    parity_even_a: assert property (s_end(g) |-> (^sh[g]) == 1'b0)
      else $error("parity not even");
  end
  reply_kind_a: assert property (nf[1] ##0 s_end(1) |->
    sh[1][7:0] inside {8'he5, 8'h68})
    else $error("reply opens with a wrong character");
  req_kind_a: assert property (nf[0] ##0 s_end(0) |->
    sh[0][7:0] inside {8'h10, 8'h68})
    else $error("request opens with a wrong character");
  half_duplex_a: assert property (
    st[1] |-> !busy[0] || cnt[0] >= 10 * B)
    else $error("meter started while master sends");
endmodule

//--- verif/meter_bus_frame_link_tb.sv
// Bench: master end and meter end talking over one optical link.
`timescale 1ns/1ps
`include "mbus_link_params.svh"
module meter_bus_frame_link_tb;
  // ------------------------------------------------------------
  // Signals and reference state
  // ------------------------------------------------------------
  // A short bit time keeps the run small; the 48-bit-time settle wait follows it.
  localparam int B = 16;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic energy_pulse = 1'b0;
  logic switch_off = 1'b0;
  logic [7:0] flag_set = 8'h00;
  logic cmd_valid = 1'b0;
  mbus_link_pkg::mcmd_t cmd_kind = mbus_link_pkg::MC_NKE;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_byte = 8'h00;
  logic rx_ok;
  logic tx_act;
  logic deny;
  logic cmd_ready;
  logic ans_valid;
  logic ans_err;
  logic [7:0] ans_byte;
  mbus_link_pkg::frame_kind_t ans_kind;
  mbus_link_pkg::frame_kind_t exp_kind;
  int mismatches = 0;
  int cmp_count = 0;
  int n_ok = 0;
  int n_deny = 0;
  int n_act = 0;
  int seed = 32'h73fb7bbf;
  logic [7:0] exp_q [$];
  logic [31:0] e_tot = 32'h0;
  logic [31:0] e_res = 32'h0;
  logic [15:0] pf = 16'h0;
  logic [15:0] rs = 16'h0;
  logic [7:0] flg = 8'h00;
  mbus_link_if link ();
  meter_end #(.BIT_CYCLES(B)) i_meter_end (.mclk(mclk), .rst(rst),
    .link(link), .energy_pulse(energy_pulse), .switch_off(switch_off),
    .flag_set(flag_set), .rx_ok(rx_ok), .tx_act(tx_act), .deny(deny));
  master_end #(.BIT_CYCLES(B)) i_master_end (.mclk(mclk), .rst(rst),
    .link(link), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .ans_valid(ans_valid), .ans_byte(ans_byte), .ans_err(ans_err),
    .ans_kind(ans_kind));
  meter_bus_frame_link_checker #(.BIT_CYCLES(B)) i_checker (.mclk(mclk),
    .rst(rst), .m2s(link.m2s), .s2m(link.s2m));
  always #2.5 mclk = ~mclk;
  // ------------------------------------------------------------
  // Compare tasks and answer monitor
  // ------------------------------------------------------------
  task automatic chk_b(input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error answer byte expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_n(input string n, input logic [15:0] e,
      input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic chk_k(input mbus_link_pkg::frame_kind_t e,
      input mbus_link_pkg::frame_kind_t g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error answer kind expected %0d seen %0d", e, g);
    end
  endtask
  always @(posedge mclk) begin
    if (rx_ok === 1'b1)
      n_ok++;
    if (deny === 1'b1)
      n_deny++;
    if (tx_act === 1'b1)
      n_act++;
    if (ans_valid === 1'b1 && exp_q.size() == 0)
      chk_b(9'h1ff, {ans_err, ans_byte});
    else if (ans_valid === 1'b1)
      chk_b({1'b0, exp_q.pop_front()}, {ans_err, ans_byte});
  end
  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic stim();
    int n;
    int m;
    n = ($random(seed) & 7) + 1;
    m = ($random(seed) & 3) + 1;
    repeat (n) begin
      energy_pulse = 1'b1;
      tick(1);
      energy_pulse = 1'b0;
      tick(1);
    end
    repeat (m) begin
      switch_off = 1'b1;
      tick(1);
      switch_off = 1'b0;
      tick(1);
    end
    flag_set = 8'($random(seed));
    tick(1);
    flg = flg | flag_set;
    flag_set = 8'h00;
    e_tot += n;
    e_res += n;
    pf += m;
  endtask
  // Reply bytes follow the object layout, each field low byte first.
  task automatic push_rsp();
    logic [111:0] p;
    logic [7:0] s;
    p = {`FW_VERSION, flg, rs, pf, e_res, e_tot};
    s = 8'h08 + 8'h72;
    exp_q = {exp_q, 8'h68, 8'h11, 8'h11, 8'h68, 8'h08, 8'h00, 8'h72};
    for (int i = 0; i < 14; i++) begin
      exp_q.push_back(p[8 * i +: 8]);
      s += p[8 * i +: 8];
    end
    exp_q = {exp_q, s, `STOP_CHAR};
    exp_kind = mbus_link_pkg::FK_LONG;
  endtask
  task automatic req(input string nm, input mbus_link_pkg::mcmd_t k,
      input logic [7:0] a, input logic [7:0] c, input int eok, input int edn);
    int ok0;
    int dn0;
    int i;
    int ac0;
    logic rp;
    ok0 = n_ok;
    dn0 = n_deny;
    ac0 = n_act;
    rp = exp_q.size() > 0;
    cmd_kind = k;
    cmd_addr = a;
    cmd_byte = c;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    for (i = 0; i < 9000 && cmd_ready !== 1'b1; i++)
      tick(1);
    for (i = 0; i < 9000 && exp_q.size() > 0; i++)
      tick(1);
    tick(48 * B);
    chk_n("answers left", 16'h0, 16'(exp_q.size()));
    if (eok >= 0)
      chk_n("rx_ok pulses", 16'(eok), 16'(n_ok - ok0));
    chk_n("deny pulses", 16'(edn), 16'(n_deny - dn0));
    chk_n("tx_act", 16'h0, {15'h0, tx_act});
    chk_n("tx_act seen", 16'(rp), 16'(n_act != ac0));
    chk_k(exp_kind, ans_kind);
    $display("test %s done", nm);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    tick(5);
    rst = 1'b0;
    exp_q.push_back(`ACK_CHAR);
    exp_kind = mbus_link_pkg::FK_ACK;
    req("init", mbus_link_pkg::MC_NKE, 8'h00, 8'h00, 1, 0);
    stim();
    push_rsp();
    req("read", mbus_link_pkg::MC_REQ, 8'h00, 8'h00, 1, 0);
    stim();
    exp_q.push_back(`ACK_CHAR);
    exp_kind = mbus_link_pkg::FK_ACK;
    req("clear", mbus_link_pkg::MC_SND, 8'h00, 8'h07, 1, 0);
    e_res = 32'h0;
    rs++;
    pf = 16'h0;
    flg &= ~`CLEARABLE_FLAGS;
    push_rsp();
    req("p2p", mbus_link_pkg::MC_REQ, 8'hfe, 8'h00, 1, 0);
    req("deny", mbus_link_pkg::MC_SND, 8'h00, 8'h08, 1, 1);
    stim();
    req("bcast", mbus_link_pkg::MC_SND, 8'hff, 8'h01, 1, 0);
    e_res = 32'h0;
    rs++;
    req("other", mbus_link_pkg::MC_REQ, 8'h05, 8'h00, 0, 0);
    push_rsp();
    req("final", mbus_link_pkg::MC_REQ, 8'h00, 8'h00, 1, 0);
    summarize();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end
endmodule
